//--- pkg/rhd_pkg.sv
// constants, field layout and timing for root hub descriptor a
package rhd_pkg;
    localparam int unsigned ADR_W         = 8;
    localparam int unsigned DAT_W         = 32;
    localparam int unsigned SEL_W         = 4;
    localparam int unsigned NUM_PORTS     = 3;

    // register byte offset and its word index
    localparam logic [7:0]  RHDA_OFFSET   = 8'h48;
    localparam logic [5:0]  RHDA_WORD     = RHDA_OFFSET[7:2];

    // field positions
    localparam int unsigned SETTLE_LSB    = 24;
    localparam int unsigned SETTLE_MSB    = 25;
    localparam int unsigned OC_DIS_BIT    = 12;
    localparam int unsigned OC_GRAN_BIT   = 11;
    localparam int unsigned COMPOUND_BIT  = 10;
    localparam int unsigned ALW_PWR_BIT   = 9;
    localparam int unsigned PORT_CNT_LSB  = 0;
    localparam int unsigned PORT_CNT_MSB  = 7;

    // byte lanes holding writable fields
    localparam int unsigned SETTLE_LANE   = 3;
    localparam int unsigned CTRL_LANE     = 1;

    // reset and fixed values
    localparam logic [31:0] RHDA_RESET    = 32'h01000003;
    localparam logic [1:0]  SETTLE_RESET  = 2'h1;
    localparam logic        OC_DIS_RESET  = 1'h0;
    localparam logic        OC_GRAN_RESET = 1'h0;
    localparam logic        ALW_PWR_RESET = 1'h0;
    localparam logic        COMPOUND_VAL  = 1'h0;
    localparam logic [7:0]  PORT_COUNT    = 8'h03;
    localparam logic [31:0] RD_IDLE       = 32'h00000000;

    // settle time is counted in units of 2 ms
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned SETTLE_UNIT_MS = 2;
    localparam int unsigned UNIT_CYCLES   = CLK_HZ / 1000 * SETTLE_UNIT_MS;
    localparam int unsigned TICK_W        = 16;

    typedef enum logic [1:0] {
        TMR_IDLE,
        TMR_RUN,
        TMR_DONE
    } rhd_tmr_state_t;
endpackage : rhd_pkg

//--- pkg/rhd_reg_if.sv
// register access carrier between bus slave and register bank
`timescale 1ns/1ns
interface rhd_reg_if;
    logic        wrEn;
    logic [3:0]  wrSel;
    logic [31:0] wrData;
    logic [31:0] rdData;

    modport slave (
        output wrEn,
        output wrSel,
        output wrData,
        input  rdData
    );
    modport bank (
        input  wrEn,
        input  wrSel,
        input  wrData,
        output rdData
    );
endinterface : rhd_reg_if

//--- src/rhd_wb_slave.sv
// classic wishbone slave front end for the descriptor register
`timescale 1ns/1ns
module rhd_wb_slave (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire logic                     wbCyc,
    input  wire logic                     wbStb,
    input  wire logic                     wbWe,
    input  wire logic [rhd_pkg::ADR_W-1:0] wbAdr,
    input  wire logic [rhd_pkg::SEL_W-1:0] wbSel,
    input  wire logic [rhd_pkg::DAT_W-1:0] wbDatIn,
    output logic      [rhd_pkg::DAT_W-1:0] wbDatOut,
    output logic                          wbAck,
    rhd_reg_if.slave                      regs
);
    logic                     ackQ;
    logic                     ackD;
    logic [rhd_pkg::DAT_W-1:0] datQ;
    logic [rhd_pkg::DAT_W-1:0] datD;
    logic                     hit;
    logic                     reqNew;

    ////////////////////////////////////////////////////////////////////////
    // decode; unmapped words still ack, reading zero, writes dropped
    always_comb begin
        hit    = 1'b0;
        if (wbAdr[7:2] == rhd_pkg::RHDA_WORD) begin
            hit = 1'b1;
        end
        reqNew = wbCyc & wbStb & ~ackQ;
        ackD   = reqNew;
        datD   = rhd_pkg::RD_IDLE;
        if (reqNew && !wbWe && hit) begin
            datD = regs.rdData;
        end
    end

    // write commits on the edge where the master sees ack
    assign regs.wrEn   = wbCyc & wbStb & wbWe & ackQ & hit & ce;
    assign regs.wrSel  = wbSel;
    assign regs.wrData = wbDatIn;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ackQ <= 1'b0;
            datQ <= rhd_pkg::RD_IDLE;
        end else if (ce) begin
            ackQ <= ackD;
            datQ <= datD;
        end
    end

    assign wbAck    = ackQ;
    assign wbDatOut = datQ;
endmodule : rhd_wb_slave

//--- src/rhd_settle_timer.sv
// counts power settle time in whole 2 ms units
`timescale 1ns/1ns
module rhd_settle_timer #(
    parameter int unsigned UNIT_CYCLES = rhd_pkg::UNIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       clear,
    input  wire logic       start,
    input  wire logic [1:0] units,
    output logic            done
);
    localparam logic [rhd_pkg::TICK_W-1:0] TICK_LAST =
        rhd_pkg::TICK_W'(UNIT_CYCLES - 1);

    rhd_pkg::rhd_tmr_state_t       stateQ;
    rhd_pkg::rhd_tmr_state_t       stateD;
    logic [rhd_pkg::TICK_W-1:0]    tickQ;
    logic [rhd_pkg::TICK_W-1:0]    tickD;
    logic [1:0]                    unitQ;
    logic [1:0]                    unitD;

    always_comb begin
        stateD = stateQ;
        tickD  = tickQ;
        unitD  = unitQ;
        case (stateQ)
            rhd_pkg::TMR_IDLE: begin
                if (start) begin
                    tickD  = '0;
                    unitD  = units;
                    // zero is illegal to program; treat as no wait
                    stateD = (units == 2'h0) ? rhd_pkg::TMR_DONE
                                             : rhd_pkg::TMR_RUN;
                end
            end
            rhd_pkg::TMR_RUN: begin
                if (tickQ == TICK_LAST) begin
                    tickD = '0;
                    unitD = unitQ - 2'h1;
                    if (unitQ == 2'h1) begin
                        stateD = rhd_pkg::TMR_DONE;
                    end
                end else begin
                    tickD = tickQ + 1'b1;
                end
            end
            rhd_pkg::TMR_DONE: begin
                stateD = rhd_pkg::TMR_DONE;
            end
            default: begin
                stateD = rhd_pkg::TMR_IDLE;
            end
        endcase
        if (clear) begin
            stateD = rhd_pkg::TMR_IDLE;
            tickD  = '0;
            unitD  = 2'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stateQ <= rhd_pkg::TMR_IDLE;
            tickQ  <= '0;
            unitQ  <= 2'h0;
        end else if (ce) begin
            stateQ <= stateD;
            tickQ  <= tickD;
            unitQ  <= unitD;
        end
    end

    assign done = (stateQ == rhd_pkg::TMR_DONE);
endmodule : rhd_settle_timer

//--- src/rhd_root_hub_desc_a.sv
// root hub descriptor a register bank with power and over-current use
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns
module rhd_root_hub_desc_a #(
    parameter int unsigned UNIT_CYCLES = rhd_pkg::UNIT_CYCLES
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic                         ce,
    input  wire logic                         hcReset,
    input  wire logic                         wbCyc,
    input  wire logic                         wbStb,
    input  wire logic                         wbWe,
    input  wire logic [rhd_pkg::ADR_W-1:0]     wbAdr,
    input  wire logic [rhd_pkg::SEL_W-1:0]     wbSel,
    input  wire logic [rhd_pkg::DAT_W-1:0]     wbDatIn,
    output logic      [rhd_pkg::DAT_W-1:0]     wbDatOut,
    output logic                              wbAck,
    input  wire logic                         powerRequest,
    input  wire logic [rhd_pkg::NUM_PORTS-1:0] ocSense,
    output logic      [rhd_pkg::NUM_PORTS-1:0] portPowerOn,
    output logic                              portPowerGood,
    output logic                              ocGlobalReport,
    output logic      [rhd_pkg::NUM_PORTS-1:0] ocPortReport
);
    localparam int unsigned NP = rhd_pkg::NUM_PORTS;

    rhd_reg_if regBus ();

    ////////////////////////////////////////////////////////////////////////
    // bus front end
    rhd_wb_slave u_wb (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wbCyc    (wbCyc),
        .wbStb    (wbStb),
        .wbWe     (wbWe),
        .wbAdr    (wbAdr),
        .wbSel    (wbSel),
        .wbDatIn  (wbDatIn),
        .wbDatOut (wbDatOut),
        .wbAck    (wbAck),
        .regs     (regBus.slave)
    );

    ////////////////////////////////////////////////////////////////////////
    // descriptor fields
    logic [1:0] settleQ;
    logic [1:0] settleD;
    logic       ocDisQ;
    logic       ocDisD;
    logic       ocGranQ;
    logic       ocGranD;
    logic       alwPwrQ;
    logic       alwPwrD;

    always_comb begin
        settleD = settleQ;
        ocDisD  = ocDisQ;
        ocGranD = ocGranQ;
        alwPwrD = alwPwrQ;
        if (regBus.wrEn) begin
            if (regBus.wrSel[rhd_pkg::SETTLE_LANE]) begin
                // upper settle bits have no storage
                settleD = regBus.wrData[rhd_pkg::SETTLE_MSB:
                                        rhd_pkg::SETTLE_LSB];
            end
            if (regBus.wrSel[rhd_pkg::CTRL_LANE]) begin
                ocDisD  = regBus.wrData[rhd_pkg::OC_DIS_BIT];
                ocGranD = regBus.wrData[rhd_pkg::OC_GRAN_BIT];
                alwPwrD = regBus.wrData[rhd_pkg::ALW_PWR_BIT];
            end
        end
    end

    // hcReset deliberately absent: only power-on reset clears fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            settleQ <= rhd_pkg::SETTLE_RESET;
            ocDisQ  <= rhd_pkg::OC_DIS_RESET;
            ocGranQ <= rhd_pkg::OC_GRAN_RESET;
            alwPwrQ <= rhd_pkg::ALW_PWR_RESET;
        end else if (ce) begin
            settleQ <= settleD;
            ocDisQ  <= ocDisD;
            ocGranQ <= ocGranD;
            alwPwrQ <= alwPwrD;
        end
    end

    // read image; reserved bits and unstored settle bits read zero
    always_comb begin
        regBus.rdData = rhd_pkg::RD_IDLE;
        regBus.rdData[rhd_pkg::SETTLE_MSB:rhd_pkg::SETTLE_LSB] = settleQ;
        regBus.rdData[rhd_pkg::OC_DIS_BIT]   = ocDisQ;
        regBus.rdData[rhd_pkg::OC_GRAN_BIT]  = ocGranQ;
        regBus.rdData[rhd_pkg::COMPOUND_BIT] = rhd_pkg::COMPOUND_VAL;
        regBus.rdData[rhd_pkg::ALW_PWR_BIT]  = alwPwrQ;
        regBus.rdData[rhd_pkg::PORT_CNT_MSB:rhd_pkg::PORT_CNT_LSB] =
            rhd_pkg::PORT_COUNT;
    end

    ////////////////////////////////////////////////////////////////////////
    // port power switching and settle tracking
    logic [NP-1:0] pwrQ;
    logic [NP-1:0] pwrD;
    logic          goodQ;
    logic          goodD;
    logic          pwrWantD;
    logic          pwrWasQ;
    logic          tmrStart;
    logic          tmrClear;
    logic          tmrDone;

    always_comb begin
        // always-powered ports ignore the request and controller reset
        pwrWantD = alwPwrQ | (powerRequest & ~hcReset);
        pwrD     = {NP{pwrWantD}};
        tmrStart = pwrWantD & ~pwrWasQ;
        tmrClear = ~pwrWantD;
        // good only once the programmed settle time has passed
        goodD    = tmrDone & pwrWantD & pwrWasQ;
    end

    rhd_settle_timer #(
        .UNIT_CYCLES (UNIT_CYCLES)
    ) u_tmr (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .clear (tmrClear),
        .start (tmrStart),
        .units (settleQ),
        .done  (tmrDone)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwrQ    <= '0;
            pwrWasQ <= 1'b0;
            goodQ   <= 1'b0;
        end else if (ce) begin
            pwrQ    <= pwrD;
            pwrWasQ <= pwrWantD;
            goodQ   <= goodD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // over-current reporting
    logic [NP-1:0] ocPortQ;
    logic [NP-1:0] ocPortD;
    logic          ocAllQ;
    logic          ocAllD;

    always_comb begin
        ocPortD = '0;
        ocAllD  = 1'b0;
        if (!ocDisQ) begin
            if (ocGranQ) begin
                ocPortD = ocSense;
            end else begin
                ocAllD = |ocSense;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ocPortQ <= '0;
            ocAllQ  <= 1'b0;
        end else if (ce) begin
            ocPortQ <= ocPortD;
            ocAllQ  <= ocAllD;
        end
    end

    assign portPowerOn    = pwrQ;
    assign portPowerGood  = goodQ;
    assign ocGlobalReport = ocAllQ;
    assign ocPortReport   = ocPortQ;
endmodule : rhd_root_hub_desc_a

//--- dv/rhd_monitor.sv
// checker for descriptor a bus, power and over-current behaviour
`timescale 1ns/1ns
module rhd_monitor #(
    parameter int unsigned UNIT_CYCLES = 10
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        hcReset,
    input wire logic        wbCyc,
    input wire logic        wbStb,
    input wire logic        wbWe,
    input wire logic [7:0]  wbAdr,
    input wire logic [3:0]  wbSel,
    input wire logic [31:0] wbDatIn,
    input wire logic [31:0] wbDatOut,
    input wire logic        wbAck,
    input wire logic        powerRequest,
    input wire logic [2:0]  ocSense,
    input wire logic [2:0]  portPowerOn,
    input wire logic        portPowerGood,
    input wire logic        ocGlobalReport,
    input wire logic [2:0]  ocPortReport
);
    logic [1:0]  setQ;
    logic [2:0]  ctlQ;
    logic [7:0]  onQ;
    logic        hit;
    logic [31:0] image;
    assign hit = wbAck && wbCyc && wbStb && wbAdr[7:2] == 6'h12;
    assign image = {6'h0, setQ, 11'h0, ctlQ[2:1], 1'b0, ctlQ[0], 9'h3};
    // shadow ignores hcReset: only power-on reset may restore it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            setQ <= 2'h1;
            ctlQ <= 3'h0;
        end else if (hit && wbWe) begin
            if (wbSel[3]) setQ <= wbDatIn[25:24];
            if (wbSel[1]) ctlQ <= {wbDatIn[12:11], wbDatIn[9]};
        end
    end
    always_ff @(posedge clk) begin
        onQ <= (!rst_n || portPowerOn == 3'h0) ? 8'h0 : onQ + 8'h1;
    end
    ////////////////////////////////////////////////////////////////////
    default clocking mcb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ack_single: assert property (wbAck |=> !wbAck)
        else $error("ack held longer than one cycle");
    chk_ack_wait: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("request not acked after one wait");
    chk_idle_data: assert property (!wbAck |-> wbDatOut == 32'h0)
        else $error("read data not zero outside a read");
    chk_read_image:
        assert property (hit && !wbWe |-> wbDatOut == image)
        else $error("register image wrong");
    chk_oc_whole:
        assert property ($past(rst_n) |-> ocGlobalReport ==
            $past(|ocSense && ctlQ[2:1] == 2'h0))
        else $error("collective report wrong");
    chk_oc_each:
        assert property ($past(rst_n) |-> ocPortReport ==
            $past(ocSense & {3{ctlQ[2:1] == 2'h1}}))
        else $error("per-port report wrong");
    chk_pwr_fixed:
        assert property ($past(rst_n && ctlQ[0]) |-> portPowerOn == 3'h7)
        else $error("always powered ports not on");
    chk_pwr_off:
        assert property ($past(rst_n && !ctlQ[0] &&
            (!powerRequest || hcReset)) |-> portPowerOn == 3'h0)
        else $error("switched ports on without request");
    chk_settle_time:
        assert property ($rose(portPowerGood) |->
            int'(onQ) + 1 >= int'(setQ) * UNIT_CYCLES &&
            int'(onQ) <= int'(setQ) * UNIT_CYCLES + 3)
        else $error("power good at wrong time");
    cov_read: cover property (hit && !wbWe);
    cov_good: cover property ($rose(portPowerGood));
    cov_each: cover property (ocPortReport != 3'h0);
endmodule : rhd_monitor

bind rhd_root_hub_desc_a rhd_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) u_mon (
    .clk(clk), .rst_n(rst_n), .ce(ce), .hcReset(hcReset), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
    .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .powerRequest(powerRequest), .ocSense(ocSense),
    .portPowerOn(portPowerOn), .portPowerGood(portPowerGood),
    .ocGlobalReport(ocGlobalReport), .ocPortReport(ocPortReport)
);

//--- dv/rhd_port_model.sv
// external port power switches with over-current sensors
`timescale 1ns/1ns
module rhd_port_model (
    input  wire logic       clk,
    input  wire logic       slow,
    input  wire logic [2:0] faultCmd,
    input  wire logic [2:0] portPowerOn,
    output logic      [2:0] ocSense
);
    logic [2:0] nearQ = 3'h0;
    logic [2:0] farQ = 3'h0;
    // a sensor trips only on a powered port
    always_ff @(posedge clk) begin
        nearQ <= faultCmd & portPowerOn;
        farQ <= nearQ;
    end
    // slow mode stands for a sluggish sensor filter
    assign ocSense = slow ? farQ : nearQ;
endmodule : rhd_port_model

//--- dv/rhd_root_hub_desc_a_tb.sv
// self-checking bench for root hub descriptor a
`timescale 1ns/1ns
module rhd_root_hub_desc_a_tb;
    localparam int unsigned UC = 10;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hcReset = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, slow = 1'b0;
    logic [7:0] wbAdr = 8'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatIn = 32'h0, wbDatOut, rdVal;
    logic powerRequest = 1'b0, wbAck, portPowerGood, ocGlobalReport;
    logic [2:0] faultCmd = 3'h0, ocSense, portPowerOn, ocPortReport;
    logic [3:0] ocExp [4] = '{4'h8, 4'h2, 4'h0, 4'h0};
    int n_errors = 0, checked = 0, cycles = 0;

    rhd_root_hub_desc_a #(.UNIT_CYCLES(UC)) dut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .hcReset(hcReset),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
        .wbAck(wbAck), .powerRequest(powerRequest), .ocSense(ocSense),
        .portPowerOn(portPowerOn), .portPowerGood(portPowerGood),
        .ocGlobalReport(ocGlobalReport), .ocPortReport(ocPortReport)
    );
    rhd_port_model sensors (
        .clk(clk), .slow(slow), .faultCmd(faultCmd),
        .portPowerOn(portPowerOn), .ocSense(ocSense)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk
    // ack sampled on the rising edge; request holds until it is seen
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {wbCyc, wbStb, wbWe} <= {2'b11, we};
        {wbAdr, wbSel, wbDatIn} <= {a, s, d};
        @(posedge clk);
        while (wbAck !== 1'b1) @(posedge clk);
        rdVal = wbDatOut;
        {wbCyc, wbStb} <= 2'b00;
    endtask : wb
    task automatic settle(input logic [1:0] s);
        int cnt;
        wb(1'b1, 8'h48, 4'h8, {6'h0, s, 24'h0});
        powerRequest <= 1'b1;
        cnt = 0;
        while (portPowerGood !== 1'b1 && cnt < 400) begin
            @(negedge clk);
            cnt++;
        end
        chk(32'(cnt >= s * UC && cnt <= s * UC + 4), 32'h1);
        @(posedge clk);
        powerRequest <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : settle
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, 8'h48, 4'hf, 32'h0);
        chk(rdVal, 32'h01000003);
        wb(1'b1, 8'h48, 4'hf, 32'hffffffff);
        wb(1'b0, 8'h48, 4'hf, 32'h0);
        chk(rdVal, 32'h03001a03);
        wb(1'b1, 8'h48, 4'h5, 32'h0);
        wb(1'b1, 8'h4c, 4'hf, 32'h0);
        wb(1'b0, 8'h48, 4'hf, 32'h0);
        chk(rdVal, 32'h03001a03);
        wb(1'b0, 8'h4c, 4'hf, 32'h0);
        chk(rdVal, 32'h0);
        wb(1'b1, 8'h48, 4'hf, 32'h01000000);
        wb(1'b1, 8'h48, 4'h2, 32'h00000200);
        repeat (3) @(negedge clk);
        chk({29'h0, portPowerOn}, 32'h7);
        wb(1'b1, 8'h48, 4'h2, 32'h0);
        repeat (3) @(negedge clk);
        chk({29'h0, portPowerOn}, 32'h0);
        // clock enable low must hold the switch off despite the request
        @(posedge clk);
        ce <= 1'b0;
        powerRequest <= 1'b1;
        repeat (4) @(negedge clk);
        chk({29'h0, portPowerOn}, 32'h0);
        @(posedge clk);
        {ce, powerRequest} <= 2'b10;
        settle(2'h1);
        settle(2'h2);
        powerRequest <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, 8'h48, 4'h2, {16'h0, 8'(i << 3), 8'h0});
            faultCmd <= 3'h2;
            slow <= i[1];
            repeat (6) @(negedge clk);
            chk(32'({ocGlobalReport, ocPortReport}),
                32'(ocExp[i]));
            @(posedge clk);
            faultCmd <= 3'h0;
        end
        wb(1'b1, 8'h48, 4'hf, 32'h02000800);
        hcReset <= 1'b1;
        @(posedge clk);
        hcReset <= 1'b0;
        @(negedge clk);
        chk({29'h0, portPowerOn}, 32'h0);
        wb(1'b0, 8'h48, 4'hf, 32'h0);
        chk(rdVal, 32'h02000803);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wb(1'b0, 8'h48, 4'hf, 32'h0);
        chk(rdVal, 32'h01000003);
        print_verdict();
    end
endmodule : rhd_root_hub_desc_a_tb
